//--- shared/erxf_pkg.sv
// receive frame steering constants, register map and field layout
// assumes a 32-bit ahb-lite slave with word-aligned registers
//
// Notes on behaviour
// - eight channels, enable bits set/cleared via set and clear registers
// - broadcast goes to the one broadcast channel when enabled, else dropped unless promiscuous mode takes it
// - group address hashed into 64-bit table; set bit sends to mcast channel
// - promiscuous channel takes control, short, error, nonmatching frames per enables
// - ram multicast entries gated by channel enables, not hash enable
// - ram result overrides hash result; ram filter drops hash match
// - address ram holds 32 entries, each match or filter
// - entry is 48-bit address, 3-bit channel, valid, match-or-filter
// - write index, then upper 32 bits, then lower 16 with flags
// - type 8100h marks tagged frame; tci bits 15-13 give priority
// - priority 0-3 and untagged frames low; 4-7 high
// - qos on: low priority dropped when free count <= low threshold
// - free count drops by one per buffer consumed on the channel, holding at zero
// - writes to free count add to it; at most 65535
// - teardown register write starts teardown after current frame
// - active channel: mark next descriptor done, clear head pointer
// - teardown raises channel interrupt, completion pointer reads fffffffc
// - inactive channel teardown interrupts too; host acks with marker
// - teardown accepted when none is pending, never clears channel enables
// - frames under 64 bytes are short: undersized or fragment
package erxf_pkg;
  // ==========================================================
  // register byte offsets
  localparam logic [7:0] CHAN_SET_OFS   = 8'h00;
  localparam logic [7:0] CHAN_CLR_OFS   = 8'h04;
  localparam logic [7:0] MBP_OFS        = 8'h08;
  localparam logic [7:0] HASH_A_OFS     = 8'h0c;
  localparam logic [7:0] HASH_B_OFS     = 8'h10;
  localparam logic [7:0] LOW_THR_OFS    = 8'h14;
  localparam logic [7:0] RAM_IDX_OFS    = 8'h18;
  localparam logic [7:0] RAM_UP_OFS     = 8'h1c;
  localparam logic [7:0] RAM_LO_OFS     = 8'h20;
  localparam logic [7:0] TDOWN_OFS      = 8'h24;
  localparam logic [7:0] IRQ_STAT_OFS   = 8'h28;
  localparam logic [7:0] FREE_BASE_OFS  = 8'h40;
  localparam logic [7:0] HDP_BASE_OFS   = 8'h60;
  localparam logic [7:0] CP_BASE_OFS    = 8'h80;
  // ==========================================================
  // steering register field positions
  localparam int MBP_MCH_LSB  = 0;
  localparam int MBP_MEN      = 5;
  localparam int MBP_BCH_LSB  = 8;
  localparam int MBP_BEN      = 13;
  localparam int MBP_PCH_LSB  = 16;
  localparam int MBP_AFEN     = 21;
  localparam int MBP_CFEN     = 22;
  localparam int MBP_SFEN     = 23;
  localparam int MBP_MFEN     = 24;
  localparam int MBP_QOS      = 29;
  localparam int LO_VALID     = 19;
  localparam int LO_MATCH     = 20;
  localparam int LO_CH_LSB    = 16;
  // ==========================================================
  // values
  localparam logic [15:0] TAG_TYPE     = 16'h8100;
  localparam logic [31:0] TDOWN_MARK   = 32'hfffffffc;
  localparam logic [10:0] SHORT_LEN    = 11'h040;
  localparam logic [31:0] RESET_WORD   = 32'h00000000;
  localparam logic [2:0]  HIGH_PRIO_MIN = 3'h4;
endpackage : erxf_pkg

//--- hw/erxf_steer.sv
// receive steering: filter decision, address ram, qos, teardown
// assumes one parsed frame header per rxFrameValid pulse, ahb-lite master
//
// Local design decisions: register access over AHB-Lite and the register offsets.
`timescale 1ns/1ps
`default_nettype none
module erxf_steer
  import erxf_pkg::*;
#(
  parameter int NUM_CHAN  = 8,
  parameter int RAM_DEPTH = 32
)(
  input  wire logic        ref_clk,
  input  wire logic        rst,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic             hresp,
  output logic [31:0]      hrdata,
  input  wire logic        rxFrameValid,
  input  wire logic [47:0] rxDestAddr,
  input  wire logic [15:0] rxLenType,
  input  wire logic [15:0] rxTagCtl,
  input  wire logic [10:0] rxFrameLen,
  input  wire logic        rxErr,
  input  wire logic        rxCtlFrame,
  input  wire logic        rxBufUsed,
  input  wire logic [2:0]  rxBufChan,
  input  wire logic        rxBusy,
  input  wire logic        descNextExists,
  input  wire logic [2:0]  busyChan,
  output logic             frameAccept_q,
  output logic [2:0]       frameChan_q,
  output logic             frameHighPrio_q,
  output logic             descDoneMark_q,
  output logic [2:0]       descDoneChan_q,
  output logic [7:0]       rxIrq_q
);
  initial
  begin
    if (NUM_CHAN != 8 || RAM_DEPTH != 32)
      $error("erxf_steer supports 8 channels and 32 entries only");
  end

  // ==========================================================
  // functions
  function automatic logic [5:0] hashIdx(input logic [47:0] a);
    logic [5:0] h;
    h = 6'h00;
    for (int i = 0; i < 8; i++)
      h = h ^ a[i*6 +: 6];
    return h;
  endfunction : hashIdx

  // ==========================================================
  // bus slave
  logic        wrPend_q;
  logic [7:0]  wrAddr_q;
  logic        rdPend_q;
  logic [7:0]  rdAddr_q;
  wire  logic  busReq = hsel && htrans[1] && hready;

  logic [7:0]  chanEn_q;
  logic [31:0] mbp_q;
  logic [31:0] hashA_q;
  logic [31:0] hashB_q;
  logic [15:0] lowThr_q;
  logic [4:0]  ramIdx_q;
  logic [31:0] ramUp_q;
  logic [47:0] ramAddr_q [RAM_DEPTH];
  logic [2:0]  ramCh_q   [RAM_DEPTH];
  logic        ramVal_q  [RAM_DEPTH];
  logic        ramMatch_q[RAM_DEPTH];
  logic [15:0] freeCnt_q [NUM_CHAN];
  logic [31:0] hdp_q     [NUM_CHAN];
  logic [31:0] cp_q      [NUM_CHAN];
  logic        tdPend_q;
  logic [2:0]  tdChan_q;

  wire logic [2:0] wSlot = wrAddr_q[4:2];
  wire logic [2:0] rSlot = rdAddr_q[4:2];
  wire logic wFree = wrPend_q && wrAddr_q[7:5] == FREE_BASE_OFS[7:5];
  wire logic wHdp  = wrPend_q && wrAddr_q[7:5] == HDP_BASE_OFS[7:5];
  wire logic wCp   = wrPend_q && wrAddr_q[7:5] == CP_BASE_OFS[7:5];
  wire logic wTd   = wrPend_q && wrAddr_q == TDOWN_OFS;

  logic [31:0] rdMux;
  always_comb
  begin
    rdMux = RESET_WORD;
    if (rdAddr_q == CHAN_SET_OFS || rdAddr_q == CHAN_CLR_OFS)
      rdMux = {24'h000000, chanEn_q};
    else if (rdAddr_q == MBP_OFS)
      rdMux = mbp_q;
    else if (rdAddr_q == HASH_A_OFS)
      rdMux = hashA_q;
    else if (rdAddr_q == HASH_B_OFS)
      rdMux = hashB_q;
    else if (rdAddr_q == LOW_THR_OFS)
      rdMux = {16'h0000, lowThr_q};
    else if (rdAddr_q == RAM_IDX_OFS)
      rdMux = {27'h0000000, ramIdx_q};
    else if (rdAddr_q == IRQ_STAT_OFS)
      rdMux = {24'h000000, rxIrq_q};
    else if (rdAddr_q[7:5] == FREE_BASE_OFS[7:5])
      rdMux = {16'h0000, freeCnt_q[rSlot]};
    else if (rdAddr_q[7:5] == HDP_BASE_OFS[7:5])
      rdMux = hdp_q[rSlot];
    else if (rdAddr_q[7:5] == CP_BASE_OFS[7:5])
      rdMux = cp_q[rSlot];
  end

  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      wrPend_q  <= 1'b0;
      rdPend_q  <= 1'b0;
      wrAddr_q  <= 8'h00;
      rdAddr_q  <= 8'h00;
      hrdata    <= 32'h00000000;
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end
    else
    begin
      wrPend_q  <= busReq && hwrite;
      rdPend_q  <= busReq && !hwrite;
      hreadyout <= !(busReq && !hwrite);
      if (busReq)
      begin
        wrAddr_q <= haddr[7:0];
        rdAddr_q <= haddr[7:0];
      end
      if (rdPend_q)
        hrdata <= rdMux;
    end
  end
  // reads take one wait state: lookup from the captured address,
  // so hrdata stands when hreadyout comes back high

  // ==========================================================
  // configuration registers
  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      chanEn_q <= 8'h00;
      mbp_q    <= RESET_WORD;
      hashA_q  <= RESET_WORD;
      hashB_q  <= RESET_WORD;
      lowThr_q <= 16'h0000;
      ramIdx_q <= 5'h00;
      ramUp_q  <= RESET_WORD;
    end
    else if (wrPend_q)
    begin
      if (wrAddr_q == CHAN_SET_OFS)
        chanEn_q <= chanEn_q | hwdata[7:0];
      else if (wrAddr_q == CHAN_CLR_OFS)
        chanEn_q <= chanEn_q & ~hwdata[7:0];
      else if (wrAddr_q == MBP_OFS)
        mbp_q <= hwdata;
      else if (wrAddr_q == HASH_A_OFS)
        hashA_q <= hwdata;
      else if (wrAddr_q == HASH_B_OFS)
        hashB_q <= hwdata;
      else if (wrAddr_q == LOW_THR_OFS)
        lowThr_q <= hwdata[15:0];
      else if (wrAddr_q == RAM_IDX_OFS)
        ramIdx_q <= hwdata[4:0];
      else if (wrAddr_q == RAM_UP_OFS)
        ramUp_q <= hwdata;
    end
  end

  // ==========================================================
  // address ram: lower-word write commits the entry
  wire logic wLo = wrPend_q && wrAddr_q == RAM_LO_OFS;
  always_ff @(posedge ref_clk)
  begin
    if (wLo)
    begin
      ramAddr_q[ramIdx_q]  <= {ramUp_q, hwdata[15:0]};
      ramCh_q[ramIdx_q]    <= hwdata[LO_CH_LSB +: 3];
      ramVal_q[ramIdx_q]   <= hwdata[LO_VALID];
      ramMatch_q[ramIdx_q] <= hwdata[LO_MATCH];
    end
  end

  // ==========================================================
  // frame classification and steering
  logic       ramHit;
  logic       ramMatchHit;
  logic [2:0] ramHitCh;
  always_comb
  begin
    ramHit      = 1'b0;
    ramMatchHit = 1'b0;
    ramHitCh    = 3'h0;
    for (int i = RAM_DEPTH - 1; i >= 0; i--)
      if (ramVal_q[i] && ramAddr_q[i] == rxDestAddr)
      begin
        ramHit      = 1'b1;
        ramMatchHit = ramMatch_q[i];
        ramHitCh    = ramCh_q[i];
      end
  end

  wire logic [63:0] hashTbl = {hashB_q, hashA_q};
  wire logic isBcast  = &rxDestAddr;
  wire logic isGroup  = rxDestAddr[40] && !isBcast;
  wire logic hashHit  = isGroup && hashTbl[hashIdx(rxDestAddr)];
  wire logic ramOk    = ramHit && ramMatchHit && chanEn_q[ramHitCh];
  wire logic ramDrop  = ramHit && !ramMatchHit;
  wire logic bcastOk  = isBcast && mbp_q[MBP_BEN];
  wire logic hashOk   = hashHit && mbp_q[MBP_MEN] && !ramDrop;
  wire logic addrMatch = !rxCtlFrame || mbp_q[MBP_CFEN];
  wire logic isShort  = rxFrameLen < SHORT_LEN;
  wire logic matched  = (ramOk || bcastOk || hashOk) && addrMatch;
  wire logic errPass  = isShort ? (mbp_q[MBP_SFEN] && (!rxErr ||
                        mbp_q[MBP_MFEN])) : (!rxErr || mbp_q[MBP_MFEN]);
  wire logic promOk   = mbp_q[MBP_AFEN] && errPass &&
                        (!rxCtlFrame || mbp_q[MBP_CFEN]);
  wire logic [2:0] matchCh = ramOk ? ramHitCh :
                             bcastOk ? mbp_q[MBP_BCH_LSB +: 3] :
                             mbp_q[MBP_MCH_LSB +: 3];
  wire logic [2:0] destCh = matched ? matchCh
                                    : mbp_q[MBP_PCH_LSB +: 3];
  wire logic isTagged = rxLenType == TAG_TYPE;
  wire logic highPrio = isTagged && rxTagCtl[15:13] >= HIGH_PRIO_MIN;
  wire logic qosDrop  = mbp_q[MBP_QOS] && !highPrio &&
                        freeCnt_q[destCh] <= lowThr_q;
  wire logic deliver  = (matched ? errPass : promOk) && !qosDrop;

  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      frameAccept_q   <= 1'b0;
      frameChan_q     <= 3'h0;
      frameHighPrio_q <= 1'b0;
    end
    else
    begin
      frameAccept_q   <= rxFrameValid && deliver;
      frameChan_q     <= destCh;
      frameHighPrio_q <= highPrio;
    end
  end

  // ==========================================================
  // free buffer counters
  always_ff @(posedge ref_clk)
  begin
    for (int c = 0; c < NUM_CHAN; c++)
    begin
      logic [16:0] sum;
      logic        dec;
      sum = {1'b0, freeCnt_q[c]};
      dec = rxBufUsed && rxBufChan == 3'(c) && freeCnt_q[c] != 16'h0000;
      if (wFree && wSlot == 3'(c))
        sum = sum + {1'b0, hwdata[15:0]};
      if (dec)
        sum = sum - 17'h00001;
      if (rst)
        freeCnt_q[c] <= 16'h0000;
      else
        freeCnt_q[c] <= sum[16] ? 16'hffff : sum[15:0];
    end
  end

  // ==========================================================
  // teardown
  wire logic tdGo = tdPend_q && !(rxBusy && busyChan == tdChan_q);
  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      tdPend_q       <= 1'b0;
      tdChan_q       <= 3'h0;
      descDoneMark_q <= 1'b0;
      descDoneChan_q <= 3'h0;
      rxIrq_q        <= 8'h00;
      for (int c = 0; c < NUM_CHAN; c++)
      begin
        hdp_q[c] <= RESET_WORD;
        cp_q[c]  <= RESET_WORD;
      end
    end
    else
    begin
      if (wTd && !tdPend_q)
      begin
        tdPend_q <= 1'b1;
        tdChan_q <= hwdata[2:0];
      end
      else if (tdGo)
        tdPend_q <= 1'b0;
      descDoneMark_q <= tdGo && hdp_q[tdChan_q] != RESET_WORD
                        && descNextExists;
      descDoneChan_q <= tdChan_q;
      for (int c = 0; c < NUM_CHAN; c++)
      begin
        if (wHdp && wSlot == 3'(c))
          hdp_q[c] <= hwdata;
        else if (tdGo && tdChan_q == 3'(c))
          hdp_q[c] <= RESET_WORD;
        if (tdGo && tdChan_q == 3'(c))
        begin
          cp_q[c]    <= TDOWN_MARK;
          rxIrq_q[c] <= 1'b1;
        end
        else if (wCp && wSlot == 3'(c))
        begin
          cp_q[c]    <= hwdata;
          rxIrq_q[c] <= 1'b0;
        end
      end
    end
  end

  // ==========================================================
  // checks
  tag_prio_a: assert property (@(posedge ref_clk) disable iff (rst)
    rxFrameValid && rxLenType != TAG_TYPE |=> !frameHighPrio_q)
    else $error("untagged frame marked high priority");
  chan_set_a: assert property (@(posedge ref_clk) disable iff (rst)
    wrPend_q && wrAddr_q == CHAN_SET_OFS |=>
    (chanEn_q & $past(hwdata[7:0])) == $past(hwdata[7:0]))
    else $error("channel set did not enable");
  td_irq_a: assert property (@(posedge ref_clk) disable iff (rst)
    tdGo |=> rxIrq_q[$past(tdChan_q)] && cp_q[$past(tdChan_q)] == TDOWN_MARK)
    else $error("teardown did not raise interrupt");
  td_en_a: assert property (@(posedge ref_clk) disable iff (rst)
    tdGo && !wrPend_q |=> chanEn_q == $past(chanEn_q))
    else $error("teardown changed channel enables");
  qos_drop_a: assert property (@(posedge ref_clk) disable iff (rst)
    rxFrameValid && qosDrop |=> !frameAccept_q)
    else $error("low priority frame not filtered");
  bcast_off_a: assert property (@(posedge ref_clk) disable iff (rst)
    rxFrameValid && isBcast && !mbp_q[MBP_BEN] && !mbp_q[MBP_AFEN]
    |=> !frameAccept_q)
    else $error("broadcast passed while disabled");
  ram_drop_a: assert property (@(posedge ref_clk) disable iff (rst)
    rxFrameValid && ramDrop && !bcastOk && !mbp_q[MBP_AFEN]
    |=> !frameAccept_q)
    else $error("ram filtered frame delivered");
  td_wait_a: assert property (@(posedge ref_clk) disable iff (rst)
    tdPend_q && rxBusy && busyChan == tdChan_q |=> !descDoneMark_q)
    else $error("teardown during active frame");
  rd_wait_a: assert property (@(posedge ref_clk) disable iff (rst)
    busReq && !hwrite |=> !hreadyout ##1 hreadyout)
    else $error("read wait state missing");
  rd_data_a: assert property (@(posedge ref_clk) disable iff (rst)
    rdPend_q && rdAddr_q == MBP_OFS |=> hrdata == $past(mbp_q))
    else $error("read data does not show the register");
  free_floor_a: assert property (@(posedge ref_clk) disable iff (rst)
    rxBufUsed && freeCnt_q[rxBufChan] == 16'h0000 && !wFree
    |=> freeCnt_q[$past(rxBufChan)] == 16'h0000)
    else $error("free count went below zero");
  free_dec_a: assert property (@(posedge ref_clk) disable iff (rst)
    rxBufUsed && freeCnt_q[rxBufChan] != 16'h0000 && !wFree
    |=> freeCnt_q[$past(rxBufChan)] == $past(freeCnt_q[rxBufChan]) - 16'h0001)
    else $error("free count not decremented");
  td_head_a: assert property (@(posedge ref_clk) disable iff (rst)
    tdGo && !wHdp |=> hdp_q[$past(tdChan_q)] == RESET_WORD)
    else $error("head pointer not cleared on teardown");
endmodule : erxf_steer
`default_nettype wire

//--- tb/erxf_rx_model.sv
// receive path model: hands parsed headers in, takes a buffer per delivered frame
// assumes the steering block answers one cycle after each header
`timescale 1ns/1ps
`default_nettype none
module erxf_rx_model (
  input  wire logic        ref_clk,
  input  wire logic        frameAccept_q,
  input  wire logic [2:0]  frameChan_q,
  input  wire logic        frameHighPrio_q,
  output logic             rxFrameValid,
  output logic [47:0]      rxDestAddr,
  output logic [15:0]      rxLenType,
  output logic [15:0]      rxTagCtl,
  output logic [10:0]      rxFrameLen,
  output logic             rxErr,
  output logic             rxCtlFrame,
  output logic             rxBufUsed,
  output logic [2:0]       rxBufChan
);
  logic [92:0] hdr;
  int          accCnt = 0;
  logic [2:0]  lastChan = 3'h0;
  logic        lastHi = 1'b0;
  assign {rxDestAddr, rxLenType, rxTagCtl, rxFrameLen, rxErr, rxCtlFrame} = hdr;
  initial
  begin
    hdr = '0;
    rxFrameValid = 1'b0;
    rxBufUsed = 1'b0;
    rxBufChan = 3'h0;
  end
  // header fields hold no old value outside the valid cycle
  task automatic send(input logic [92:0] f);
    @(posedge ref_clk);
    rxFrameValid <= 1'b1;
    hdr <= f;
    @(posedge ref_clk);
    rxFrameValid <= 1'b0;
    hdr <= ~f;
  endtask : send
  // one buffer is used on the channel of each delivered frame
  always @(posedge ref_clk)
  begin
    rxBufUsed <= frameAccept_q;
    rxBufChan <= frameAccept_q ? frameChan_q : ~rxBufChan;
    if (frameAccept_q === 1'b1)
    begin
      accCnt++;
      lastChan = frameChan_q;
      lastHi = frameHighPrio_q;
    end
  end
endmodule : erxf_rx_model
`default_nettype wire

//--- tb/erxf_steer_tb_top.sv
// testbench for the receive steering block over ahb-lite
// assumes erxf_rx_model on the frame side and a 200 MHz ref_clk
`timescale 1ns/1ps
`default_nettype none
module erxf_steer_tb_top
  import erxf_pkg::*;
;
  logic        ref_clk, rst, hsel, hwrite, hreadyout, hresp;
  logic        rxFrameValid, rxErr, rxCtlFrame, rxBufUsed, rxBusy;
  logic        descNextExists, frameAccept_q, frameHighPrio_q;
  logic        descDoneMark_q;
  logic [1:0]  htrans, fl;
  logic [2:0]  hsize, rxBufChan, busyChan, frameChan_q, descDoneChan_q;
  logic [2:0]  uc, mc, markCh;
  logic [4:0]  ix;
  logic [7:0]  rxIrq_q, en, fa;
  logic [10:0] rxFrameLen, ln;
  logic [15:0] rxLenType, rxTagCtl;
  logic [31:0] haddr, hwdata, hrdata;
  logic [47:0] rxDestAddr, ua, ma;
  int          err_total = 0;
  int          checks_done = 0;
  int          seed = 1703;
  int          markCnt = 0;

  erxf_steer dut_u (
    .ref_clk, .rst, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
    .hready(hreadyout), .hreadyout, .hresp, .hrdata, .rxFrameValid,
    .rxDestAddr, .rxLenType, .rxTagCtl, .rxFrameLen, .rxErr, .rxCtlFrame,
    .rxBufUsed, .rxBufChan, .rxBusy, .descNextExists, .busyChan,
    .frameAccept_q, .frameChan_q, .frameHighPrio_q, .descDoneMark_q,
    .descDoneChan_q, .rxIrq_q);
  erxf_rx_model rxm_u (
    .ref_clk, .frameAccept_q, .frameChan_q, .frameHighPrio_q, .rxFrameValid,
    .rxDestAddr, .rxLenType, .rxTagCtl, .rxFrameLen, .rxErr, .rxCtlFrame,
    .rxBufUsed, .rxBufChan);

  initial
  begin
    ref_clk = 1'b0;
    forever #2.5 ref_clk = ~ref_clk;
  end
  always @(posedge ref_clk)
  begin
    if (descDoneMark_q === 1'b1)
    begin
      markCnt++;
      markCh = descDoneChan_q;
    end
  end
  // ==========================================================
  // checks and bus cycles
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp)
    begin
      err_total++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic give_verdict();
    $display("checks %0d errors %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : give_verdict
  task automatic bus(input logic [7:0] a, input logic wr,
                     input logic [31:0] d, output logic [31:0] q);
    @(posedge ref_clk);
    haddr <= {24'h0, a};
    hwrite <= wr;
    htrans <= 2'b10;
    hsel <= 1'b1;
    @(posedge ref_clk);
    while (hreadyout !== 1'b1) @(posedge ref_clk);
    htrans <= 2'b00;
    hsel <= 1'b0;
    hwdata <= d;
    @(posedge ref_clk);
    while (hreadyout !== 1'b1) @(posedge ref_clk);
    chk({31'h0, hresp}, 32'h0);
    q = hrdata;
  endtask : bus
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(a, 1'b1, d, q);
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] q;
    bus(a, 1'b0, $random(seed), q);
    chk(q, e);
  endtask : rd
  task automatic ent(input logic [4:0] i, input logic [47:0] a,
                     input logic [2:0] c, input logic v, input logic m);
    wr(RAM_IDX_OFS, {27'h0, i});
    wr(RAM_UP_OFS, a[47:16]);
    wr(RAM_LO_OFS, {11'h0, m, v, c, a[15:0]});
  endtask : ent
  function automatic logic hi(input logic [15:0] lt, input logic [15:0] t);
    return lt == 16'h8100 && t[15:13] > 3'h3;
  endfunction : hi
  task automatic frm(input logic [47:0] d, input logic [15:0] lt,
    input logic [15:0] t, input logic [10:0] l, input logic [1:0] f,
    input logic acc, input logic [2:0] c);
    int n;
    n = rxm_u.accCnt;
    rxm_u.send({d, lt, t, l, f});
    repeat (2) @(posedge ref_clk);
    chk(32'(rxm_u.accCnt - n), {31'h0, acc});
    if (acc)
    begin
      chk({29'h0, rxm_u.lastChan}, {29'h0, c});
      chk({31'h0, rxm_u.lastHi}, {31'h0, hi(lt, t)});
    end
  endtask : frm
  task automatic tdown(input logic [2:0] c, input logic busy, input int mk);
    int n;
    int m0;
    m0 = markCnt;
    rxBusy <= busy;
    busyChan <= c;
    wr(TDOWN_OFS, {29'h0, c});
    repeat (8) @(posedge ref_clk);
    chk({31'h0, rxIrq_q[c]}, {31'h0, !busy});
    rxBusy <= 1'b0;
    busyChan <= ~c;
    n = 0;
    while (rxIrq_q[c] !== 1'b1 && n < 64)
    begin
      @(posedge ref_clk);
      n++;
    end
    repeat (3) @(posedge ref_clk);
    chk({31'h0, rxIrq_q[c]}, 32'h1);
    chk(32'(markCnt - m0), 32'(mk));
    if (mk != 0) chk({29'h0, markCh}, {29'h0, c});
    rd(HDP_BASE_OFS + {3'h0, c, 2'h0}, 32'h0);
    rd(CP_BASE_OFS + {3'h0, c, 2'h0}, 32'hfffffffc);
    rd(CHAN_CLR_OFS, {24'h0, en});
    wr(CP_BASE_OFS + {3'h0, c, 2'h0}, 32'hfffffffc);
    repeat (2) @(posedge ref_clk);
    chk({31'h0, rxIrq_q[c]}, 32'h0);
  endtask : tdown
  // ==========================================================
  // main sequence
  initial
  begin
    rst = 1'b1;
    {hsel, hwrite, htrans, haddr, hwdata} = '0;
    {rxBusy, busyChan, descNextExists} = '0;
    hsize = 3'h2;
    repeat (16) @(posedge ref_clk);
    rst <= 1'b0;
    chk({23'h0, hreadyout, rxIrq_q}, 32'h100);
    rd(8'hfc, 32'h0);
    for (int i = 0; i < 32; i++) ent(5'(i), {$random(seed), 16'h0}, 3'h0, 0, 0);
    for (int c = 0; c < 8; c++) wr(HDP_BASE_OFS + 8'(4 * c), 32'h0);
    ua = {$random(seed), 16'h0} ^ 48'($random(seed));
    ua[40] = 1'b0;
    uc = 3'($random(seed));
    mc = uc + 3'h1;
    ent(5'h1f, ua, uc, 1'b1, 1'b1);
    frm(ua, 16'h0800, 16'h0, 11'h100, 2'b00, 1'b0, uc);
    en = (8'h1 << uc) | (8'h1 << mc);
    wr(CHAN_SET_OFS, {24'h0, 8'h1 << uc});
    frm(ua, 16'h0800, 16'h0, 11'h100, 2'b00, 1'b1, uc);
    ma = ua ^ 48'h0100_0000_0007;
    ix = 5'($random(seed)) & 5'h1e;
    ent(ix, ma, mc, 1'b1, 1'b1);
    wr(HASH_A_OFS, 32'hffffffff);
    wr(HASH_B_OFS, 32'hffffffff);
    frm(ma, 16'h0800, 16'h0, 11'h80, 2'b00, 1'b0, mc);
    wr(CHAN_SET_OFS, {24'h0, 8'h1 << mc});
    frm(ma, 16'h0800, 16'h0, 11'h80, 2'b00, 1'b1, mc);
    wr(CHAN_CLR_OFS, {24'h0, 8'h1 << mc});
    rd(CHAN_CLR_OFS, {24'h0, 8'h1 << uc});
    frm(ma, 16'h0800, 16'h0, 11'h80, 2'b00, 1'b0, mc);
    wr(CHAN_SET_OFS, {24'h0, 8'h1 << mc});
    wr(MBP_OFS, 32'h20 | 32'(uc));
    frm(ma ^ 48'h10, 16'h0800, 16'h0, 11'h80, 2'b00, 1'b1, uc);
    ent(ix, ma, mc, 1'b1, 1'b0);
    frm(ma, 16'h0800, 16'h0, 11'h80, 2'b00, 1'b0, mc);
    wr(HASH_A_OFS, 32'h0);
    wr(HASH_B_OFS, 32'h0);
    frm(ma ^ 48'h10, 16'h0800, 16'h0, 11'h80, 2'b00, 1'b0, uc);
    frm('1, 16'h0800, 16'h0, 11'h80, 2'b00, 1'b0, mc);
    wr(MBP_OFS, 32'h2000 | (32'(mc) << 8));
    frm('1, 16'h0800, 16'h0, 11'h80, 2'b00, 1'b1, mc);
    wr(MBP_OFS, 32'h0020_0000 | (32'(mc) << 16));
    frm(ua ^ 48'h300, 16'h0800, 16'h0, 11'h40, 2'b00, 1'b1, mc);
    for (int j = 0; j < 3; j++)
    begin
      fl = (j == 2) ? 2'b10 : (j == 0) ? 2'b01 : 2'b00;
      ln = (j == 1) ? 11'h03f : 11'h040;
      wr(MBP_OFS, 32'h0020_0000 | (32'(mc) << 16));
      frm(ua ^ 48'h300, 16'h0800, 16'h0, ln, fl, 1'b0, mc);
      wr(MBP_OFS, 32'h0020_0000 | (32'h0040_0000 << j) | (32'(mc) << 16));
      frm(ua ^ 48'h300, 16'h0800, 16'h0, ln, fl, 1'b1, mc);
    end
    wr(MBP_OFS, 32'h0);
    for (int p = 0; p < 8; p++)
      frm(ua, 16'h8100, {3'(p), 13'($random(seed))}, 11'h80, 2'b00, 1'b1, uc);
    frm(ua, 16'h88a8, 16'he000, 11'h80, 2'b00, 1'b1, uc);
    fa = FREE_BASE_OFS + {3'h0, uc, 2'h0};
    wr(MBP_OFS, 32'h2000_0000);
    wr(LOW_THR_OFS, 32'h2);
    wr(fa, 32'h3);
    wr(fa, 32'h1);
    rd(fa, 32'h4);
    repeat (2) frm(ua, 16'h0800, 16'h0, 11'h80, 2'b00, 1'b1, uc);
    rd(fa, 32'h2);
    frm(ua, 16'h0800, 16'h0, 11'h80, 2'b00, 1'b0, uc);
    repeat (3) frm(ua, 16'h8100, 16'he000, 11'h80, 2'b00, 1'b1, uc);
    rd(fa, 32'h0);
    wr(fa, 32'hffff);
    wr(fa, 32'h5);
    rd(fa, 32'hffff);
    wr(MBP_OFS, 32'h0);
    descNextExists <= 1'b1;
    wr(HDP_BASE_OFS + {3'h0, uc, 2'h0}, 32'h100);
    tdown(uc, 1'b1, 1);
    tdown(mc, 1'b0, 0);
    give_verdict();
  end
  initial
  begin
    #200000;
    err_total++;
    give_verdict();
  end
endmodule : erxf_steer_tb_top
`default_nettype wire
